// >>> src/message_send_function.sv
// Message send handshake: start/abort sequencing, parameter list and result words
//
// Overview of operation
// R1: A rising start command begins message send processing.
// R2: Program holds start high until completion or error appears.
// R3: Program drops start for at least one scan between messages.
// R4: Abort rising abandons the message; abort beats a simultaneous start.
// R5: Busy stays high throughout send or abort processing.
// R6: Program keeps its raised command high while busy is high.
// R7: Completion pulses for exactly one scan after normal end.
// R8: Error pulses for exactly one scan when sending fails.
// R9: Device type 1 link, 5 serial port, 6/16 Ethernet, 11 fieldbus.
// R10: Protocol 1 selects request-response family, device converts variant.
// R11: Protocols 2 and 3 send raw words or bytes, no response awaited.
// R12: Circuit 1..16 for serial port, 1..8 for every other device.
// R13: Channel 1..12 link, 1 serial port, 1..10 Ethernet, 1..4 fieldbus.
// R14: Program never shares a channel between concurrent functions on one modem.
// R15: Ethernet offers ten channels shared by send and receive.
// R16: Seventeen words from the base address form the parameter list.
// R17: Program instantiates one function per concurrently used circuit.
// R18: Result word upper byte: 00 busy, 10 complete, 8y error.
// R19: Each scan is one enable tick; start edge found against previous scan.
// R20: Busy drops with the pulse; a held start is ignored until low.
`timescale 1ns/100ps
module message_send_function (
	// Clock, reset, scan enable
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	input  wire logic                      scan_en,
	// Commands from the program
	input  wire logic                      start_cmd,
	input  wire logic                      abort_cmd,
	// Selectors from the program
	input  wire logic [15:0]               dev_type,
	input  wire logic [15:0]               proto_type,
	input  wire logic [15:0]               circuit_number,
	input  wire logic [15:0]               buffer_channel_number,
	input  wire logic [15:0]               param_base_addr,
	// Status toward the program
	output logic                           busy,
	output logic                           complete,
	output logic                           error,
	// Parameter list memory port
	output logic [15:0]                    pl_addr,
	output logic                           pl_rd,
	output logic                           pl_wr,
	output logic [15:0]                    pl_wdata,
	input  wire logic [15:0]               pl_rdata,
	// Transmission device request
	output logic                           tx_start,
	output logic                           tx_abort,
	output msg_send_pkg::dev_class_t       tx_dev,
	output logic                           tx_eth_b,
	output logic [1:0]                     tx_proto,
	output logic                           tx_noresp,
	output logic [15:0]                    tx_cir,
	output logic [15:0]                    tx_ch,
	// Transmission device answer
	input  wire logic                      tx_done,
	input  wire logic                      tx_err,
	input  wire logic [7:0]                tx_err_code,
	input  wire logic [15:0]               tx_status,
	// Parameter word readback for the device
	input  wire logic [3:0]                tx_pword_sel,
	output logic [15:0]                    tx_pword
);

	msg_send_pkg::msg_state_t st_r;
	msg_send_pkg::msg_state_t st_nxt;

	// ------------------------------------------------------------
	// Selector decode
	// ------------------------------------------------------------
	msg_send_pkg::dev_class_t dev_class;
	logic                     dev_eth_b;
	logic [15:0]              cir_max;
	logic [15:0]              ch_max;
	logic                     cir_ok;
	logic                     ch_ok;
	logic                     proto_ok;
	logic [3:0]               chk_code;
	logic                     start_edge;
	logic                     abort_edge;

	// Device type picks the class and its circuit and channel limits
	always_comb begin
		dev_class = msg_send_pkg::DEVC_NONE;
		dev_eth_b = 1'b0;
		cir_max   = `CIR_MAX_OTHER;                       // R12
		ch_max    = 16'h0000;
		case (dev_type)
			`DEV_SERIAL_LINK: begin                       // R9
				dev_class = msg_send_pkg::DEVC_SERIAL_LINK;
				ch_max    = `CH_MAX_LINK;                 // R13
			end
			`DEV_SERIAL_PORT: begin                       // R9
				dev_class = msg_send_pkg::DEVC_SERIAL_PORT;
				cir_max   = `CIR_MAX_PORT;                // R12
				ch_max    = `CH_MAX_PORT;                 // R13
			end
			`DEV_ETH_A: begin                             // R9
				dev_class = msg_send_pkg::DEVC_ETH;
				ch_max    = `CH_MAX_ETH;                  // R15
			end
			`DEV_ETH_B: begin                             // R9
				dev_class = msg_send_pkg::DEVC_ETH;
				dev_eth_b = 1'b1;
				ch_max    = `CH_MAX_ETH;                  // R15
			end
			`DEV_FIELDBUS: begin                          // R9
				dev_class = msg_send_pkg::DEVC_FIELDBUS;
				ch_max    = `CH_MAX_BUS;                  // R13
			end
			default: begin
				dev_class = msg_send_pkg::DEVC_NONE;
			end
		endcase
	end

	// Circuit number window
	range_check #(
		.W (16)
	) u_cir_check (
		.value    (circuit_number),
		.lo       (`NUM_MIN),
		.hi       (cir_max),
		.in_range (cir_ok)
	);

	// Channel number window; an unknown device yields a zero bound
	range_check #(
		.W (16)
	) u_ch_check (
		.value    (buffer_channel_number),
		.lo       (`NUM_MIN),
		.hi       (ch_max),
		.in_range (ch_ok)
	);

	// Only the three protocol codes are accepted
	always_comb begin
		proto_ok = (proto_type == `PROTO_REQRESP) ||      // R10
		           (proto_type == `PROTO_RAW_WORD) ||     // R11
		           (proto_type == `PROTO_RAW_BYTE);       // R11
	end

	// First failing check names the error detail
	always_comb begin
		if (dev_class == msg_send_pkg::DEVC_NONE) begin
			chk_code = `ERR_DEV;
		end else if (!proto_ok) begin
			chk_code = `ERR_PROTO;
		end else if (!cir_ok) begin
			chk_code = `ERR_CIR;
		end else if (!ch_ok) begin
			chk_code = `ERR_CH;
		end else begin
			chk_code = `ERR_NONE;
		end
	end

	// Edges are taken against the level seen in the previous scan
	always_comb begin
		start_edge = start_cmd && !st_r.start_prev && st_r.start_armed;    // R19
		abort_edge = abort_cmd && !st_r.abort_prev && st_r.abort_armed;    // R4
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Pulses default low so each lasts one scan
	always_comb begin
		st_nxt            = st_r;
		st_nxt.start_prev = start_cmd;
		st_nxt.abort_prev = abort_cmd;
		st_nxt.complete   = 1'b0;
		st_nxt.error      = 1'b0;
		st_nxt.pl_rd      = 1'b0;
		st_nxt.pl_wr      = 1'b0;
		st_nxt.tx_start   = 1'b0;
		st_nxt.tx_abort   = 1'b0;
		st_nxt.tx_pword   = (tx_pword_sel < 4'(`N_IN_WORDS)) ?
		                    st_r.pwords[tx_pword_sel] : `RESET_WORD;

		// A held command re-arms only once it has been seen low
		if (!start_cmd) begin
			st_nxt.start_armed = 1'b1;                    // R20
		end
		if (!abort_cmd) begin
			st_nxt.abort_armed = 1'b1;
		end

		case (st_r.state)
			msg_send_pkg::ST_IDLE: begin
				if (abort_edge || start_edge) begin       // R1
					st_nxt.busy     = 1'b1;               // R5
					st_nxt.aborting = abort_edge;         // R4
					st_nxt.err_code = abort_edge ? `ERR_NONE : chk_code;
					st_nxt.sys_byte = `RESET_BYTE;
					st_nxt.tx_dev   = dev_class;
					st_nxt.tx_eth_b = dev_eth_b;
					st_nxt.tx_proto = proto_type[1:0];
					st_nxt.tx_cir   = circuit_number;
					st_nxt.tx_ch    = buffer_channel_number;
					st_nxt.tx_noresp = (proto_type != `PROTO_REQRESP);    // R11
					// Mark the list busy before anything else
					st_nxt.pl_addr  = param_base_addr + 16'(`W_RESULT);   // R16
					st_nxt.pl_wdata = {`RES_BUSY, `RESET_BYTE};           // R18
					st_nxt.pl_wr    = 1'b1;
					st_nxt.state    = msg_send_pkg::ST_MARK;
				end
			end
			msg_send_pkg::ST_MARK: begin
				st_nxt.rd_idx  = `W_FIRST_IN;
				st_nxt.rd_pend = 1'b0;
				if (abort_cmd || st_r.aborting || st_r.err_code != `ERR_NONE) begin
					st_nxt.aborting = st_r.aborting || abort_cmd;          // R4
					st_nxt.state    = msg_send_pkg::ST_FINISH;
				end else begin
					st_nxt.state = msg_send_pkg::ST_LOAD;
				end
			end
			msg_send_pkg::ST_LOAD: begin
				// Read pipeline: issue one word, capture the one issued before
				if (st_r.rd_pend) begin
					st_nxt.pwords[st_r.cap_idx] = pl_rdata;               // R16
				end
				if (abort_cmd) begin
					// Nothing has reached the device yet, so abort ends at once
					st_nxt.aborting = 1'b1;                               // R4
					st_nxt.rd_pend  = 1'b0;
					st_nxt.state    = msg_send_pkg::ST_FINISH;
				end else if (st_r.rd_idx <= `W_LAST_IN) begin
					st_nxt.pl_addr = param_base_addr + 16'(st_r.rd_idx);  // R16
					st_nxt.pl_rd   = 1'b1;
					st_nxt.cap_idx = 4'(st_r.rd_idx - `W_FIRST_IN);
					st_nxt.rd_pend = 1'b1;
					st_nxt.rd_idx  = st_r.rd_idx + 5'h01;
				end else begin
					st_nxt.rd_pend  = 1'b0;
					st_nxt.tx_start = 1'b1;                               // R1
					st_nxt.state    = msg_send_pkg::ST_SEND;
				end
			end
			msg_send_pkg::ST_SEND: begin
				if (abort_cmd) begin
					st_nxt.aborting = 1'b1;                               // R4
					st_nxt.tx_abort = 1'b1;
					st_nxt.state    = msg_send_pkg::ST_ABORT;
				end else if (tx_err) begin
					st_nxt.err_code = `ERR_TX;                            // R8
					st_nxt.sys_byte = tx_err_code;
					st_nxt.status   = tx_status;
					st_nxt.state    = msg_send_pkg::ST_STAT;
				end else if (tx_done) begin
					st_nxt.status = tx_status;
					st_nxt.state  = msg_send_pkg::ST_STAT;
				end
			end
			msg_send_pkg::ST_ABORT: begin
				// Busy stays up until the device confirms the abort
				if (tx_err) begin
					st_nxt.err_code = `ERR_TX;
					st_nxt.sys_byte = tx_err_code;
					st_nxt.status   = tx_status;
					st_nxt.state    = msg_send_pkg::ST_STAT;
				end else if (tx_done) begin
					st_nxt.status = tx_status;
					st_nxt.state  = msg_send_pkg::ST_STAT;
				end
			end
			msg_send_pkg::ST_STAT: begin
				st_nxt.pl_addr  = param_base_addr + 16'(`W_STATUS);       // R16
				st_nxt.pl_wdata = st_r.status;
				st_nxt.pl_wr    = 1'b1;
				st_nxt.state    = msg_send_pkg::ST_FINISH;
			end
			msg_send_pkg::ST_FINISH: begin
				// Result word, pulse and busy release land in the same scan
				st_nxt.pl_addr = param_base_addr + 16'(`W_RESULT);
				st_nxt.pl_wr   = 1'b1;
				if (st_r.err_code != `ERR_NONE) begin
					st_nxt.pl_wdata = {`RES_ERR_NIB, st_r.err_code, st_r.sys_byte}; // R18
					st_nxt.error    = 1'b1;                               // R8
				end else begin
					st_nxt.pl_wdata = {`RES_DONE, st_r.sys_byte};         // R18
					st_nxt.complete = 1'b1;                               // R7
				end
				st_nxt.busy = 1'b0;                                       // R20
				// The command that drove this run must fall before it counts again
				if (st_r.aborting) begin
					st_nxt.abort_armed = 1'b0;
				end
				st_nxt.start_armed = !st_r.aborting ? 1'b0 : !start_cmd;  // R20
				st_nxt.aborting    = 1'b0;
				st_nxt.state       = msg_send_pkg::ST_IDLE;
			end
			default: begin
				st_nxt.busy  = 1'b0;
				st_nxt.state = msg_send_pkg::ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// One scan is one enabled edge; everything freezes between scans
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r             <= '0;
			st_r.state       <= msg_send_pkg::ST_IDLE;
			st_r.tx_dev      <= msg_send_pkg::DEVC_NONE;
			st_r.start_prev  <= 1'b1;
			st_r.abort_prev  <= 1'b1;
			st_r.start_armed <= 1'b0;
			st_r.abort_armed <= 1'b0;
		end else if (scan_en) begin
			st_r <= st_nxt;                                               // R19
		end
	end

	// ------------------------------------------------------------
	// Outputs, straight from the state register
	// ------------------------------------------------------------
	assign busy      = st_r.busy;                                         // R5
	assign complete  = st_r.complete;
	assign error     = st_r.error;
	assign pl_addr   = st_r.pl_addr;
	assign pl_rd     = st_r.pl_rd;
	assign pl_wr     = st_r.pl_wr;
	assign pl_wdata  = st_r.pl_wdata;
	assign tx_start  = st_r.tx_start;
	assign tx_abort  = st_r.tx_abort;
	assign tx_dev    = st_r.tx_dev;
	assign tx_eth_b  = st_r.tx_eth_b;
	assign tx_proto  = st_r.tx_proto;
	assign tx_noresp = st_r.tx_noresp;
	assign tx_cir    = st_r.tx_cir;
	assign tx_ch     = st_r.tx_ch;
	assign tx_pword  = st_r.tx_pword;

endmodule

// >>> common/msg_send_regs.svh
// Constants of the message send handshake block: list offsets, codes, limits
`ifndef MSG_SEND_REGS_SVH
`define MSG_SEND_REGS_SVH

// ------------------------------------------------------------
// Parameter list layout (word offsets from the base address)
// ------------------------------------------------------------
`define PLIST_WORDS      17
`define W_RESULT         5'h00
`define W_STATUS         5'h01
`define W_FIRST_IN       5'h02
`define W_LAST_IN        5'h0B
`define N_IN_WORDS       10

// ------------------------------------------------------------
// Result word upper byte codes
// ------------------------------------------------------------
`define RES_BUSY         8'h00
`define RES_DONE         8'h10
`define RES_ERR_NIB      4'h8

// ------------------------------------------------------------
// Error detail nibble (the y of the error code)
// ------------------------------------------------------------
`define ERR_NONE         4'h0
`define ERR_DEV          4'h1
`define ERR_PROTO        4'h2
`define ERR_CIR          4'h3
`define ERR_CH           4'h4
`define ERR_TX           4'h5

// ------------------------------------------------------------
// Device type codes
// ------------------------------------------------------------
`define DEV_SERIAL_LINK  16'h0001
`define DEV_SERIAL_PORT  16'h0005
`define DEV_ETH_A        16'h0006
`define DEV_FIELDBUS     16'h000B
`define DEV_ETH_B        16'h0010

// ------------------------------------------------------------
// Protocol codes
// ------------------------------------------------------------
`define PROTO_REQRESP    16'h0001
`define PROTO_RAW_WORD   16'h0002
`define PROTO_RAW_BYTE   16'h0003

// ------------------------------------------------------------
// Circuit and channel limits
// ------------------------------------------------------------
`define NUM_MIN          16'h0001
`define CIR_MAX_PORT     16'h0010
`define CIR_MAX_OTHER    16'h0008
`define CH_MAX_LINK      16'h000C
`define CH_MAX_PORT      16'h0001
`define CH_MAX_ETH       16'h000A
`define CH_MAX_BUS       16'h0004

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RESET_WORD       16'h0000
`define RESET_BYTE       8'h00

`endif

// >>> common/msg_send_pkg.sv
// Types of the message send handshake block
package msg_send_pkg;
	`include "msg_send_regs.svh"

	// ------------------------------------------------------------
	// Sequencer states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE   = 7'b000_0001,
		ST_MARK   = 7'b000_0010,
		ST_LOAD   = 7'b000_0100,
		ST_SEND   = 7'b000_1000,
		ST_ABORT  = 7'b001_0000,
		ST_STAT   = 7'b010_0000,
		ST_FINISH = 7'b100_0000
	} seq_state_t;

	// ------------------------------------------------------------
	// Transmission device class
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DEVC_NONE        = 3'h0,
		DEVC_SERIAL_LINK = 3'h1,
		DEVC_SERIAL_PORT = 3'h2,
		DEVC_ETH         = 3'h3,
		DEVC_FIELDBUS    = 3'h4
	} dev_class_t;

	// ------------------------------------------------------------
	// Whole state of the block
	// ------------------------------------------------------------
	typedef struct packed {
		seq_state_t                         state;
		logic                               start_prev;
		logic                               abort_prev;
		logic                               start_armed;
		logic                               abort_armed;
		logic                               aborting;
		logic                               busy;
		logic                               complete;
		logic                               error;
		logic [3:0]                         err_code;
		logic [7:0]                         sys_byte;
		logic [15:0]                        status;
		logic [15:0]                        pl_addr;
		logic                               pl_rd;
		logic                               pl_wr;
		logic [15:0]                        pl_wdata;
		logic [4:0]                         rd_idx;
		logic [3:0]                         cap_idx;
		logic                               rd_pend;
		logic [`N_IN_WORDS-1:0][15:0]       pwords;
		logic                               tx_start;
		logic                               tx_abort;
		dev_class_t                         tx_dev;
		logic                               tx_eth_b;
		logic [1:0]                         tx_proto;
		logic                               tx_noresp;
		logic [15:0]                        tx_cir;
		logic [15:0]                        tx_ch;
		logic [15:0]                        tx_pword;
	} msg_state_t;
endpackage

// >>> src/range_check.sv
// Inclusive range check of one integer input
`timescale 1ns/100ps
module range_check #(
	parameter int W = 16
) (
	// Value and bounds
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] lo,
	input  wire logic [W-1:0] hi,
	// Result
	output logic              in_range
);
	// A zero upper bound marks an unknown device and rejects everything
	always_comb begin
		in_range = (hi != '0) && (value >= lo) && (value <= hi);
	end
endmodule

// >>> bench/msg_send_sva.sv
// Port assertions for the message send handshake block
`timescale 1ns/100ps
`include "msg_send_regs.svh"
module msg_send_sva (
	// Clock, reset and scan
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        scan_en,
	// Program side
	input wire logic        start_cmd,
	input wire logic        abort_cmd,
	input wire logic [15:0] param_base_addr,
	input wire logic        busy,
	input wire logic        complete,
	input wire logic        error,
	// Parameter list and device request
	input wire logic [15:0] pl_addr,
	input wire logic        pl_rd,
	input wire logic        pl_wr,
	input wire logic [15:0] pl_wdata,
	input wire logic        tx_start
);
	logic start_prev_r;
	logic abort_prev_r;

	// Last scan's levels; high out of reset so a held command waits
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			start_prev_r <= 1'b1;
			abort_prev_r <= 1'b1;
		end else if (scan_en) begin
			start_prev_r <= start_cmd;
			abort_prev_r <= abort_cmd;
		end
	end

	// ------------------------------------------------------------
	// Handshake properties
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_START_ACCEPT: assert property (
		scan_en && start_cmd && !start_prev_r && !abort_cmd && !busy && !complete && !error
		|=> busy && pl_wr && pl_addr == param_base_addr && pl_wdata == `RESET_WORD)
		else $error("start edge not taken");
	AST_ABORT_WINS: assert property (
		scan_en && abort_cmd && !abort_prev_r && start_cmd && !start_prev_r && !busy
		&& !complete && !error |=> busy && !tx_start ##1 busy && !tx_start ##1 complete)
		else $error("abort did not override start");
	AST_BUSY_END: assert property (
		$fell(busy) && $past(rst_n) |-> complete || error)
		else $error("busy dropped without a result");
	AST_PULSE_BUSY: assert property (
		complete || error |-> !busy && $past(busy))
		else $error("result pulse outside a run");
	AST_DONE_ONE: assert property (
		complete && scan_en |=> !complete)
		else $error("complete longer than one scan");
	AST_ERR_ONE: assert property (
		error && scan_en |=> !error)
		else $error("error longer than one scan");
	AST_HELD_START: assert property (
		scan_en && !busy && start_cmd && start_prev_r && !abort_cmd |=> !busy)
		else $error("held start began a run");
	AST_RESULT_OK: assert property (
		complete |-> pl_wr && pl_addr == param_base_addr && pl_wdata[15:8] == `RES_DONE)
		else $error("complete without done result word");
	AST_RESULT_ERR: assert property (
		error |-> pl_wr && pl_addr == param_base_addr && pl_wdata[15:12] == `RES_ERR_NIB)
		else $error("error without error result word");
	AST_LIST_SPAN: assert property (
		pl_rd || pl_wr |-> 16'(pl_addr - param_base_addr) < 16'h0011)
		else $error("access outside the parameter list");
endmodule

// >>> bench/plist_model.sv
// Parameter list memory and transmission device facing the block
`timescale 1ns/100ps
module plist_model (
	// Clock
	input wire logic        core_clk,
	// Parameter list port
	input wire logic [15:0] pl_addr,
	input wire logic        pl_rd,
	input wire logic        pl_wr,
	input wire logic [15:0] pl_wdata,
	output logic     [15:0] pl_rdata,
	// Device request and answer
	input wire logic        tx_start,
	input wire logic        tx_abort,
	output logic            tx_done,
	output logic            tx_err,
	output logic     [7:0]  tx_err_code,
	output logic     [15:0] tx_status,
	// Answer behaviour chosen by the bench
	input wire logic [7:0]  resp_delay,
	input wire logic        resp_err
);
	logic [15:0] mem [256];
	logic [8:0]  wait_r;
	logic [15:0] last_status;
	logic [7:0]  last_code;
	int          n_start;

	// Known fill for the pword checks
	initial begin
		foreach (mem[i]) mem[i] = 16'(i * 16'h0107 ^ 16'h5a3c);
		{tx_done, tx_err, tx_err_code, tx_status, wait_r} = '0;
		n_start = 0;
	end

	// Reads answer at once; an idle port shows the inverse
	assign pl_rdata = pl_rd ? mem[pl_addr[7:0]] : ~mem[pl_addr[7:0]];
	// Writes and device answers
	always @(posedge core_clk) begin
		logic [15:0] s;
		logic [7:0]  c;
		s = 16'($urandom);
		c = 8'($urandom);
		if (pl_wr) mem[pl_addr[7:0]] <= pl_wdata;
		tx_status <= s;
		tx_err_code <= c;
		tx_done <= 1'b0;
		tx_err <= 1'b0;
		if (tx_start) begin
			n_start++;
			wait_r <= {1'b0, resp_delay} + 9'h001;
		end else if (tx_abort && wait_r != 9'h000) begin
			wait_r <= 9'h001;
		end else if (wait_r == 9'h001) begin
			wait_r <= 9'h000;
			tx_done <= !resp_err;
			tx_err <= resp_err;
			last_status <= s;
			last_code <= c;
		end else if (wait_r != 9'h000) begin
			wait_r <= wait_r - 9'h001;
		end
	end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the message send handshake block
`timescale 1ns/100ps
`include "msg_send_regs.svh"
`define CHK(what, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) begin \
			failures++; \
			$display("BAD %s expected %h seen %h", what, exp, got); \
		end \
	end
module testbench;
	logic core_clk, rst_n, scan_en, start_cmd, abort_cmd, resp_err;
	logic [15:0] dev_type, proto_type, circuit_number, buffer_channel_number;
	logic [15:0] param_base_addr, pl_addr, pl_wdata, pl_rdata, tx_cir, tx_ch;
	logic [15:0] tx_status, tx_pword;
	logic busy, complete, error, pl_rd, pl_wr, tx_start, tx_abort, tx_eth_b;
	logic tx_noresp, tx_done, tx_err;
	logic [1:0] tx_proto;
	logic [3:0] tx_pword_sel;
	logic [7:0] tx_err_code, resp_delay;
	msg_send_pkg::dev_class_t tx_dev;
	int failures = 0;
	int n_compared = 0;
	logic [15:0] devs [5] = '{`DEV_SERIAL_LINK, `DEV_SERIAL_PORT, `DEV_ETH_A,
		`DEV_FIELDBUS, `DEV_ETH_B};
	logic [15:0] cmx [5] = '{`CIR_MAX_OTHER, `CIR_MAX_PORT, `CIR_MAX_OTHER,
		`CIR_MAX_OTHER, `CIR_MAX_OTHER};
	logic [15:0] hmx [5] = '{`CH_MAX_LINK, `CH_MAX_PORT, `CH_MAX_ETH, `CH_MAX_BUS,
		`CH_MAX_ETH};

	message_send_function dut (.*);
	plist_model mdl (.*);

	always #50 core_clk = ~core_clk;

	// Expected error detail, in the block's check order
	function automatic logic [3:0] exp_err(input logic [15:0] d, p, c, h);
		foreach (devs[i])
			if (d == devs[i])
				return (p < `PROTO_REQRESP || p > `PROTO_RAW_BYTE) ? `ERR_PROTO :
					(c < `NUM_MIN || c > cmx[i]) ? `ERR_CIR :
					(h < `NUM_MIN || h > hmx[i]) ? `ERR_CH : `ERR_NONE;
		return `ERR_DEV;
	endfunction

	function automatic msg_send_pkg::dev_class_t exp_dev(input logic [15:0] d);
		case (d)
			`DEV_SERIAL_LINK: return msg_send_pkg::DEVC_SERIAL_LINK;
			`DEV_SERIAL_PORT: return msg_send_pkg::DEVC_SERIAL_PORT;
			`DEV_FIELDBUS: return msg_send_pkg::DEVC_FIELDBUS;
			default: return msg_send_pkg::DEVC_ETH;
		endcase
	endfunction

	// One request; mode 0 plain, 1 abort in mid-send, 2 abort rising with start
	task automatic run(input logic [15:0] d, p, c, h, input int dly, input logic e,
			input int mode);
		logic [3:0] y;
		logic [15:0] base;
		logic [7:0] exp_hi;
		logic ok, got_c, got_e;
		int n, s0;
		y = (mode == 2) ? `ERR_NONE : exp_err(d, p, c, h);
		ok = (y == `ERR_NONE) && !e;
		exp_hi = (y != 0) ? {`RES_ERR_NIB, y} : e ? {`RES_ERR_NIB, `ERR_TX} : `RES_DONE;
		base = 16'($urandom % 200);
		s0 = mdl.n_start;
		@(posedge core_clk);
		start_cmd <= 1'b0;
		abort_cmd <= 1'b0;
		{dev_type, proto_type, circuit_number, buffer_channel_number} <= {d, p, c, h};
		{param_base_addr, resp_delay, resp_err} <= {base, 8'(dly), e};
		@(posedge core_clk);
		start_cmd <= 1'b1;
		abort_cmd <= (mode == 2);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
			if (mode == 1 && tx_start) begin
				for (int i = 0; i < 12; i++) begin
					@(posedge core_clk);
					tx_pword_sel <= 4'(i);
					@(posedge core_clk);
					#1;
					`CHK("pword", i < 10 ? mdl.mem[8'(base + 2 + i)] : 16'h0000, tx_pword)
				end
				@(posedge core_clk);
				abort_cmd <= 1'b1;
			end
		end while (!complete && !error && n < 400);
		got_c = complete;
		got_e = error;
		@(posedge core_clk);
		#1;
		`CHK("complete", ok, got_c)
		`CHK("error", !ok, got_e)
		`CHK("idle", 1'b0, busy)
		`CHK("sends", 32'(mode != 2 && y == 0), mdl.n_start - s0)
		`CHK("result", exp_hi, mdl.mem[base[7:0]][15:8])
		if (e && y == 0)
			`CHK("sys", mdl.last_code, mdl.mem[base[7:0]][7:0])
		if (ok && mode != 2) begin
			`CHK("status", mdl.last_status, mdl.mem[8'(base + 1)])
			`CHK("dev", exp_dev(d), tx_dev)
			`CHK("eth_b", d == `DEV_ETH_B, tx_eth_b)
			`CHK("noresp", p != `PROTO_REQRESP, tx_noresp)
			`CHK("cir", c, tx_cir)
			`CHK("ch", h, tx_ch)
		end
	endtask

	task test_done;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog: a run needs under a thousand scans
	initial begin
		#5_000_000;
		failures++;
		test_done();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(77960));
		{core_clk, rst_n, start_cmd, abort_cmd, resp_err, tx_pword_sel} = '0;
		{dev_type, proto_type, circuit_number, buffer_channel_number} = '0;
		{param_base_addr, resp_delay} = '0;
		scan_en = 1'b1;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		// Each device at its limits, one past them, and faulted
		foreach (devs[i]) begin
			run(devs[i], `PROTO_REQRESP, cmx[i], hmx[i], 3, 1'b0, 0);
			run(devs[i], `PROTO_RAW_WORD, cmx[i] + 16'h0001, `NUM_MIN, 0, 1'b0, 0);
			run(devs[i], `PROTO_RAW_BYTE, `NUM_MIN, hmx[i] + 16'h0001, 0, 1'b0, 0);
			run(devs[i], `PROTO_RAW_WORD, `NUM_MIN, `NUM_MIN, 1, 1'b1, 0);
		end
		$display("test limits done");
		run(`DEV_ETH_B, `PROTO_REQRESP, `NUM_MIN, `CH_MAX_ETH, 100, 1'b0, 1);
		run(`DEV_SERIAL_PORT, `PROTO_RAW_BYTE, `NUM_MIN, `NUM_MIN, 0, 1'b0, 2);
		$display("test abort done");
		// Reset while the list is being read
		@(posedge core_clk);
		{start_cmd, abort_cmd} <= 2'b00;
		@(posedge core_clk);
		start_cmd <= 1'b1;
		repeat (6) @(posedge core_clk) scan_en <= !scan_en;
		`CHK("freeze", param_base_addr + 16'h0002, pl_addr)
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		`CHK("reset", 4'h0, {busy, complete, error, tx_start})
		$display("test reset done");
		repeat (40)
			run(($urandom % 4 == 0) ? 16'($urandom % 18) : devs[$urandom % 5],
				16'($urandom % 5), 16'($urandom % 18), 16'($urandom % 14),
				$urandom % 6, ($urandom % 6) == 0, 0);
		$display("test random done");
		test_done();
	end
endmodule

bind message_send_function msg_send_sva chk (.*);
